// [hw/interval_timer.sv]
// Interval and time-base timer with registers and overflow interrupt
//
// Functional notes
// [RQ1] With the time-base bit at 0 the counter counts the system prescaler tap chosen by the low select bits.
// [RQ2] Select codes 0 to 7 pick system clock divided by 8192, 4096, 2048, 512, 256, 128, 32 and 8.
// [RQ3] With the time-base bit at 1 the counter counts watch prescaler taps giving 1 s, 0.5 s, 0.25 s or 31.25 ms overflow.
// [RQ4] Time-base bit and select bit 2 both at 1 hold the counter and the watch prescaler at zero.
// [RQ5] Codes above 1100 behave exactly like code 1100.
// [RQ6] The counter is an 8-bit read-only up-counter that advances only on the selected tick.
// [RQ7] Counter reads return the count in active mode and are unsupported (read zero) in subactive mode.
// [RQ8] A tick while the counter holds ff sets the overflow request flag.
// [RQ9] The interrupt output rises on overflow only while the overflow interrupt enable is 1.
// [RQ10] On overflow the counter wraps to zero and keeps counting, one overflow per 256 ticks.
// [RQ11] Reset clears the counter and the time-base bit so interval counting starts at once.
// [RQ12] Standby control bit 0 of the clock-stop register at 0 puts the timer in module standby; 1 releases it.
// [RQ13] Interval counting runs in active and sleep, time base also in watch and sub modes, mode register writable in active and subactive.
// [RQ14] The subclock passes a synchroniser into the system clock domain.
// [RQ15] Writes to the time-base bit are ignored while the standby control bit is 0.
// [RQ16] Software sets the standby control bit before changing the time-base bit.
// [RQ17] Software writes zeros to the top three mode bits; bit 4 reads as 1 and never changes.
`timescale 1ns/1ps
`include "timer_params.svh"
module interval_timer #(
    parameter int COUNT_WIDTH = 8
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic subclk_in,
    input wire timer_pkg::power_mode_e power_mode_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    output logic irq_out
);
    localparam int TAPS[8] = `TMR_TAP_LOG2;

    ////////////////////////////////////////////////////////////////
    // Declarations
    logic [3:0] mode_q;
    logic [COUNT_WIDTH-1:0] count_q;
    logic [7:0] clkstop_q;
    logic ovf_flag_q;
    logic ovf_en_q;
    logic [7:0] rdata_q;
    logic [`TMR_PSS_WIDTH-1:0] pss_q;
    logic [7:0] pss_tap_w;
    logic standby_bit_w;
    logic time_base_w;
    logic tb_clear_w;
    logic interval_run_w;
    logic base_run_w;
    logic tick_w;
    logic overflow_w;
    logic mode_wr_ok_w;
    logic wr_mode_w;
    logic wr_clkstop_w;
    logic wr_mask_w;
    logic rd_status_w;
    logic [7:0] rd_mux_w;

    watch_tick_if wt ();

    ////////////////////////////////////////////////////////////////
    // Decoded control
    assign standby_bit_w = clkstop_q[`TMR_STANDBY_BIT];
    assign time_base_w = mode_q[`TMR_MODE_TB_BIT];
    // Codes 1100 to 1111 all land here, so the reserved ones act as 1100
    assign tb_clear_w = time_base_w && mode_q[`TMR_MODE_SEL2_BIT]; // RQ4 RQ5

    // Run windows per power state; module standby stops both
    always_comb begin
        interval_run_w = 1'b0;
        base_run_w = 1'b0;
        unique case (power_mode_in)
            timer_pkg::PWR_ACTIVE, timer_pkg::PWR_SLEEP: begin
                interval_run_w = standby_bit_w; // RQ13 RQ12
                base_run_w = standby_bit_w;
            end
            timer_pkg::PWR_WATCH, timer_pkg::PWR_SUBACTIVE,
            timer_pkg::PWR_SUBSLEEP: begin
                base_run_w = standby_bit_w; // RQ13
            end
            timer_pkg::PWR_STANDBY: begin
                base_run_w = 1'b0;
            end
            default: begin
                base_run_w = 1'b0;
            end
        endcase
    end

    // Mode register only changes in active and subactive
    assign mode_wr_ok_w = (power_mode_in == timer_pkg::PWR_ACTIVE) ||
                          (power_mode_in == timer_pkg::PWR_SUBACTIVE); // RQ13

    ////////////////////////////////////////////////////////////////
    // System prescaler, free running from reset
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pss_q <= '0;
        end else begin
            pss_q <= pss_q + 1'b1;
        end
    end

    // One tap per select code, each a one-cycle enable at its rate
    for (genvar i = 0; i < 8; i++) begin : g_pss_tap
        assign pss_tap_w[i] = &pss_q[TAPS[i]-1:0]; // RQ2
    end

    ////////////////////////////////////////////////////////////////
    // Watch prescaler connection
    assign wt.clear = tb_clear_w;
    assign wt.run = time_base_w && base_run_w;
    assign wt.period_sel = mode_q[1:0];

    watch_prescaler u_watch_prescaler (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .subclk_in(subclk_in),
        .wt(wt)
    );

    ////////////////////////////////////////////////////////////////
    // Counter clock selection
    always_comb begin
        if (time_base_w) begin
            tick_w = wt.tick; // RQ3
        end else begin
            tick_w = interval_run_w && pss_tap_w[mode_q[2:0]]; // RQ1
        end
    end

    assign overflow_w = tick_w && (count_q == COUNT_WIDTH'(`TMR_COUNT_MAX)); // RQ8

    ////////////////////////////////////////////////////////////////
    // Up-counter, cleared by reset or the time-base clear code
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            count_q <= COUNT_WIDTH'(`TMR_COUNT_RESET); // RQ11
        end else if (tb_clear_w) begin
            count_q <= '0; // RQ4
        end else if (tick_w) begin
            count_q <= count_q + 1'b1; // RQ6 RQ10
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register write and status read decode
    assign wr_mode_w = wr_in && (addr_in == `TMR_OFF_MODE) && mode_wr_ok_w;
    assign wr_clkstop_w = wr_in && (addr_in == `TMR_OFF_CLKSTOP);
    assign wr_mask_w = wr_in && (addr_in == `TMR_OFF_IRQ_MASK);
    assign rd_status_w = rd_in && (addr_in == `TMR_OFF_IRQ_STATUS);

    // Mode register: select bits always, time-base bit only out of module standby
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            mode_q <= `TMR_MODE_RESET; // RQ11
        end else if (wr_mode_w) begin
            mode_q[2:0] <= wdata_in[2:0];
            if (standby_bit_w) begin
                mode_q[`TMR_MODE_TB_BIT] <= wdata_in[`TMR_MODE_TB_BIT]; // RQ15
            end
        end
    end

    // Clock-stop register; only bit 0 acts here, the rest are kept for readback
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            clkstop_q <= `TMR_CLKSTOP_RESET; // RQ12
        end else if (wr_clkstop_w) begin
            clkstop_q <= wdata_in;
        end
    end

    // Overflow interrupt enable
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ovf_en_q <= 1'b0;
        end else if (wr_mask_w) begin
            ovf_en_q <= wdata_in[`TMR_OVF_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // Sticky overflow flag: cleared by reading it, a new overflow wins
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            ovf_flag_q <= 1'b0;
        end else if (overflow_w) begin
            ovf_flag_q <= 1'b1; // RQ8
        end else if (rd_status_w) begin
            ovf_flag_q <= 1'b0;
        end
    end

    // Level interrupt while the flag is set and enabled
    assign irq_out = ovf_flag_q && ovf_en_q; // RQ9

    ////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux_w = 8'h00;
        unique case (addr_in)
            `TMR_OFF_MODE: begin
                rd_mux_w[3:0] = mode_q;
                rd_mux_w[`TMR_MODE_ONE_BIT] = 1'b1; // RQ17
            end
            `TMR_OFF_COUNT: begin
                if (power_mode_in != timer_pkg::PWR_SUBACTIVE) begin
                    rd_mux_w = 8'(count_q); // RQ7
                end
            end
            `TMR_OFF_CLKSTOP: begin
                rd_mux_w = clkstop_q;
            end
            `TMR_OFF_IRQ_STATUS: begin
                rd_mux_w[`TMR_OVF_BIT] = ovf_flag_q;
            end
            `TMR_OFF_IRQ_MASK: begin
                rd_mux_w[`TMR_OVF_BIT] = ovf_en_q;
            end
            default: begin
                rd_mux_w = 8'h00;
            end
        endcase
    end

    // Read data stands for the cycle after the strobe only
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h00;
        end else if (rd_in) begin
            rdata_q <= rd_mux_w;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign rdata_out = rdata_q;
endmodule

// [include/timer_params.svh]
// Constants for the interval and time-base timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Register offsets on the plain register port
`define TMR_OFF_MODE 3'h0
`define TMR_OFF_COUNT 3'h1
`define TMR_OFF_CLKSTOP 3'h2
`define TMR_OFF_IRQ_STATUS 3'h3
`define TMR_OFF_IRQ_MASK 3'h4

// Mode register field positions
`define TMR_MODE_TB_BIT 3
`define TMR_MODE_SEL2_BIT 2
`define TMR_MODE_ONE_BIT 4

// Reset values and the counter maximum
`define TMR_MODE_RESET 4'h0
`define TMR_COUNT_RESET 8'h00
`define TMR_CLKSTOP_RESET 8'hff
`define TMR_COUNT_MAX 8'hff

// Clock stop and interrupt bit positions
`define TMR_STANDBY_BIT 0
`define TMR_OVF_BIT 0

// System prescaler taps, as log2 of the divide ratio, code 0 to code 7
`define TMR_PSS_WIDTH 13
`define TMR_TAP_LOG2 '{13, 12, 11, 9, 8, 7, 5, 3}

// Watch prescaler: log2 of subclock edges per count for each overflow period
`define TMR_PSW_WIDTH 7
`define TMR_PSW_LOG2 '{7, 6, 5, 2}

`endif

// [include/timer_pkg.sv]
// Types shared by the interval and time-base timer
package timer_pkg;

    // Chip power state as seen by the timer
    typedef enum logic [2:0] {
        PWR_ACTIVE,
        PWR_SLEEP,
        PWR_WATCH,
        PWR_SUBACTIVE,
        PWR_SUBSLEEP,
        PWR_STANDBY
    } power_mode_e;

    typedef logic [7:0] byte_t;

endpackage

// [include/watch_tick_if.sv]
// Signals between the timer core and its watch prescaler
`timescale 1ns/1ps
interface watch_tick_if;
    logic clear;
    logic run;
    logic [1:0] period_sel;
    logic tick;

    modport core (
        output clear,
        output run,
        output period_sel,
        input tick
    );

    modport prescaler (
        input clear,
        input run,
        input period_sel,
        output tick
    );
endinterface

// [hw/watch_prescaler.sv]
// Subclock synchroniser and watch prescaler with overflow-period taps
`timescale 1ns/1ps
`include "timer_params.svh"
module watch_prescaler (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic subclk_in,
    watch_tick_if.prescaler wt
);
    localparam int TAPS[4] = `TMR_PSW_LOG2;

    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic [`TMR_PSW_WIDTH-1:0] psw_q;
    logic edge_w;
    logic [3:0] tap_w;

    ////////////////////////////////////////////////////////////////
    // Two-flop synchroniser, third flop only for edge detection
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= subclk_in; // RQ14
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign edge_w = sync2_q && !sync3_q;

    ////////////////////////////////////////////////////////////////
    // Watch prescaler counts subclock edges; clear has priority
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            psw_q <= '0;
        end else if (wt.clear) begin
            psw_q <= '0; // RQ4
        end else if (wt.run && edge_w) begin
            psw_q <= psw_q + 1'b1;
        end
    end

    // A tap fires when its low bits roll over
    for (genvar i = 0; i < 4; i++) begin : g_tap
        assign tap_w[i] = (&psw_q[TAPS[i]-1:0]) && edge_w && wt.run && !wt.clear;
    end

    assign wt.tick = tap_w[wt.period_sel]; // RQ3
endmodule

// [verif/interval_timer_chk.sv]
// Port assertions for the interval and time-base timer
`timescale 1ns/1ps
module interval_timer_chk #(
    parameter int COUNT_WIDTH = 8
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic subclk_in,
    input wire timer_pkg::power_mode_e power_mode_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire logic irq_out
);
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);
    // Strobe decodes per register
    wire rd_m = rd_in && addr_in == 3'h0;
    wire rd_c = rd_in && addr_in == 3'h1;
    wire rd_s = rd_in && addr_in == 3'h2;
    wire wr_m = wr_in && addr_in == 3'h0 && power_mode_in == timer_pkg::PWR_ACTIVE;
    wire wr_s = wr_in && addr_in == 3'h2;
    ////////////////////////////////////////////////////////////////////////////
    property p_rdata_idle;
        !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    property p_sub_read;
        rd_c && power_mode_in == timer_pkg::PWR_SUBACTIVE |=> rdata_out == 8'h00;
    endproperty
    a_sub_read: assert property (p_sub_read)
        else $error("count readable in subactive");
    property p_mode_fixed;
        rd_m |=> rdata_out[7:4] == 4'h1;
    endproperty
    a_mode_fixed: assert property (p_mode_fixed)
        else $error("mode upper bits wrong");
    property p_count_step;
        rd_c ##1 rd_c |=> 8'(rdata_out - $past(rdata_out)) <= 8'h01;
    endproperty
    a_count_step: assert property (p_count_step)
        else $error("count jumped by more than one");
    property p_clkstop_back;
        wr_s ##1 rd_s |=> rdata_out == $past(wdata_in, 2);
    endproperty
    a_clkstop_back: assert property (p_clkstop_back)
        else $error("clock stop readback wrong");
    property p_mode_back;
        wr_m ##1 rd_m |=> ((rdata_out ^ $past(wdata_in, 2)) & 8'h07) == 8'h00;
    endproperty
    a_mode_back: assert property (p_mode_back)
        else $error("mode select readback wrong");
    property p_irq_mask;
        wr_in && addr_in == 3'h4 && !wdata_in[0] |=> !irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("interrupt high while disabled");
    property p_irq_fall;
        $fell(irq_out) |-> $past(rd_in && addr_in == 3'h3) || $past(wr_in && addr_in == 3'h4);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("interrupt dropped without cause");
    // Main scenarios reached
    c_irq: cover property ($rose(irq_out));
    c_step: cover property (rd_c ##1 rd_c);
    c_sub: cover property (rd_c && power_mode_in == timer_pkg::PWR_SUBACTIVE);
endmodule

bind interval_timer interval_timer_chk #(.COUNT_WIDTH(COUNT_WIDTH)) i_interval_timer_chk (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .subclk_in(subclk_in),
    .power_mode_in(power_mode_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out)
);

// [verif/tb_interval_timer.sv]
// Self-checking bench for the interval and time-base timer
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_interval_timer;
    logic clock_in, rst_n_in, subclk_in, wr_in, rd_in, irq_out;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out;
    timer_pkg::power_mode_e power_mode_in;
    int n_mismatch = 0;
    int check_count = 0;
    int cyc = 0;
    interval_timer i_interval_timer (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .subclk_in(subclk_in), .power_mode_in(power_mode_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .irq_out(irq_out));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, fast subclock and hang guard
    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc % 10 == 0) subclk_in <= ~subclk_in;
        if (cyc == 80000) begin
            n_mismatch++;
            complete_run;
        end
    end
    // Register bus cycles, called right after a rising edge; back-to-back writes take one edge each
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    // Read data is taken at the edge that closes the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        @(posedge clock_in);
        d = rdata_out;
    endtask
    // Count advance over a fixed gap between two reads
    task automatic rate(input logic [7:0] m, input int d, input logic [7:0] n);
        logic [7:0] a, b;
        wr(3'h0, m);
        rd(3'h1, a);
        repeat (d - 2) @(posedge clock_in);
        rd(3'h1, b);
        `CHK("count advance", n, 8'(b - a))
    endtask
    task automatic wait_irq(output int t);
        for (int i = 0; i < 3000 && irq_out !== 1'b1; i++) begin
            @(posedge clock_in);
        end
        t = cyc;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, back-to-back count reads, unmapped read
    task automatic t_reset;
        logic [7:0] v;
        rst_n_in <= 1'b0;
        repeat (5) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        rd(3'h0, v);
        `CHK("mode", 8'h10, v)
        rd(3'h1, v);
        `CHK("count", 8'h00, v)
        // Two count reads back to back, each answered in the following cycle
        rd_in <= 1'b1;
        addr_in <= 3'h1;
        @(posedge clock_in);
        @(posedge clock_in);
        rd_in <= 1'b0;
        `CHK("first count", 8'h00, rdata_out)
        @(posedge clock_in);
        `CHK("second count", 8'h00, rdata_out)
        rd(3'h2, v);
        `CHK("clock stop", 8'hff, v)
        rd(3'h5, v);
        `CHK("unmapped", 8'h00, v)
    endtask
    // Every interval tap and every time-base period, then clear code 1100 and reserved code 1111
    task automatic t_rates;
        int div[8] = '{8192, 4096, 2048, 512, 256, 128, 32, 8};
        int ed[4] = '{128, 64, 32, 4};
        logic [7:0] v;
        for (int k = 0; k < 8; k++) begin
            rate(8'(k), 2 * div[k], 8'h02);
        end
        for (int k = 0; k < 4; k++) begin
            rate(8'h08 + 8'(k), 20 * ed[k], 8'h01);
        end
        wr(3'h0, 8'h0c);
        repeat (3) @(posedge clock_in);
        rd(3'h1, v);
        `CHK("cleared count", 8'h00, v)
        wr(3'h0, 8'h0f);
        repeat (200) @(posedge clock_in);
        rd(3'h1, v);
        `CHK("reserved code count", 8'h00, v)
    endtask
    // Module standby halts counting and locks the time-base bit
    task automatic t_standby;
        logic [7:0] a, b;
        wr(3'h0, 8'h07);
        @(posedge clock_in);
        wr(3'h2, 8'hfe);
        rd(3'h2, a);
        `CHK("clock stop", 8'hfe, a)
        rd(3'h1, a);
        repeat (64) @(posedge clock_in);
        rd(3'h1, b);
        `CHK("halted count", a, b)
        wr(3'h0, 8'h0f);
        rd(3'h0, a);
        `CHK("locked mode", 8'h17, a)
        wr(3'h2, 8'hff);
        @(posedge clock_in);
        wr(3'h0, 8'h0b);
        rd(3'h0, a);
        `CHK("unlocked mode", 8'h1b, a)
    endtask
    // Power states: subactive read, watch halt, sleep retention
    task automatic t_power;
        logic [7:0] a, b;
        wr(3'h0, 8'h07);
        power_mode_in <= timer_pkg::PWR_SUBACTIVE;
        rd(3'h1, a);
        `CHK("subactive read", 8'h00, a)
        wr(3'h0, 8'h06);
        rd(3'h0, a);
        `CHK("subactive write", 8'h16, a)
        power_mode_in <= timer_pkg::PWR_WATCH;
        rd(3'h1, a);
        repeat (64) @(posedge clock_in);
        rd(3'h1, b);
        `CHK("watch halt", a, b)
        power_mode_in <= timer_pkg::PWR_STANDBY;
        rd(3'h1, a);
        repeat (64) @(posedge clock_in);
        rd(3'h1, b);
        `CHK("standby halt", a, b)
        power_mode_in <= timer_pkg::PWR_SLEEP;
        wr(3'h0, 8'h05);
        rd(3'h0, a);
        `CHK("sleep retain", 8'h16, a)
        // Time base keeps counting in watch; the mode write inside rate is ignored there
        power_mode_in <= timer_pkg::PWR_ACTIVE;
        wr(3'h0, 8'h0b);
        @(posedge clock_in);
        power_mode_in <= timer_pkg::PWR_WATCH;
        rate(8'h0b, 160, 8'h02);
        power_mode_in <= timer_pkg::PWR_ACTIVE;
    endtask
    // Overflow flag, interrupt gating, read clear and period
    task automatic t_ovf;
        logic [7:0] s;
        logic seen;
        int t0, t1;
        wr(3'h4, 8'h01);
        @(posedge clock_in);
        wr(3'h0, 8'h07);
        rd(3'h3, s);
        wait_irq(t0);
        `CHK("irq raised", 1'b1, irq_out)
        rd(3'h3, s);
        `CHK("flag", 8'h01, s)
        `CHK("irq cleared", 1'b0, irq_out)
        wait_irq(t1);
        `CHK("overflow period", 2048, t1 - t0)
        wr(3'h4, 8'h00);
        rd(3'h3, s);
        seen = 1'b0;
        repeat (2100) begin
            @(posedge clock_in);
            seen = seen | irq_out;
        end
        `CHK("masked irq", 1'b0, seen)
        rd(3'h3, s);
        `CHK("masked flag", 8'h01, s)
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Main sequence, ending with a second reset in mid-run
    initial begin
        rst_n_in = 1'b0;
        subclk_in = 1'b0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        power_mode_in = timer_pkg::PWR_ACTIVE;
        t_reset;
        t_rates;
        t_standby;
        t_power;
        t_ovf;
        t_reset;
        complete_run;
    end
endmodule
